// file: pdk_pkg.sv
// package for the panel dial and key lock block
package pdk_pkg;
	// ************************************************************
	// bus and register map
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SETTINGS = 8'h04;
	localparam logic [7:0] ADDR_FREQ = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_CMD = 8'h10;
	localparam logic [7:0] ADDR_LIST = 8'h14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ************************************************************
	// field reset values, codes and limits
	// ************************************************************
	localparam logic [3:0] LOCK_SEL_RST = 4'h0;
	localparam logic [3:0] LOCK_ARM_FREQ = 4'hA;
	localparam logic [3:0] LOCK_ARM_POT = 4'hB;
	localparam logic [2:0] STEP_RST = 3'h0;
	localparam logic BEEP_RST = 1'b1;
	localparam logic [5:0] CONTRAST_RST = 6'h3A;
	localparam logic [5:0] CONTRAST_MAX = 6'h3F;
	localparam logic [13:0] EXT_SIMPLE = 14'h270F;
	localparam logic [13:0] EXT_RST = 14'h270F;
	localparam logic [19:0] FREQ_RST = 20'h00000;
	// frequency held in 0.01 Hz units
	localparam logic [19:0] FREQ_100 = 20'h02710;
	localparam logic [19:0] SPEED_1000 = 20'h186A0;
	localparam logic [19:0] FREQ_MAX = 20'h02EE0;
	localparam logic [4:0] CLICKS_PER_REV = 5'h18;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_MHZ = 125;
	localparam int HOLD_MS = 2000;
	localparam int HOLD_CYCLES = HOLD_MS * 1000 * CLK_MHZ;
	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		PDK_UNLOCKED = 2'b00,
		PDK_LOCKED = 2'b01,
		PDK_NOTICE = 2'b11
	} pdk_lock_e;
	typedef struct packed {
		logic [3:0] lock_sel;
		logic [2:0] step_sel;
		logic beep_en;
		logic [5:0] contrast;
		logic [13:0] ext_disp;
		logic speed_disp;
		logic write_protect;
	} pdk_cfg_s;
	// step code to 0.01 Hz units: 0 and 1 = 0.01, 2..4 = 0.1, 1, 10
	function automatic logic [19:0] pdk_step(input logic [2:0] code);
		unique case (code)
			3'h1: pdk_step = 20'h00001;
			3'h2: pdk_step = 20'h0000A;
			3'h3: pdk_step = 20'h00064;
			3'h4: pdk_step = 20'h003E8;
			default: pdk_step = 20'h00001;
		endcase
	endfunction : pdk_step
endpackage : pdk_pkg

// file: pdk_panel.sv
// operation panel lock, dial step and settings block with an axi4-lite slave
`timescale 1ns/1ps
module pdk_panel import pdk_pkg::*; #(
	parameter int HOLD_COUNT = HOLD_CYCLES
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// panel pins
	input wire logic mode_key_in,
	input wire logic set_key_in,
	input wire logic stop_key_in,
	input wire logic dial_a_in,
	input wire logic dial_b_in,
	input wire logic panel_operation_in,
	input wire logic setting_freq_in,
	// panel outputs
	output logic lock_notice_out,
	output logic restore_error_out,
	output logic stop_out,
	output logic key_beep_out,
	output logic [5:0] lcd_contrast_out
);
	// ************************************************************
	// input synchronisers
	// ************************************************************
	logic [6:0] pin_meta_reg;
	logic [6:0] pin_sync_reg;
	logic [6:0] pin_prev_reg;
	always_ff @(posedge sys_clk_in) begin
		pin_meta_reg <= {mode_key_in, set_key_in, stop_key_in, dial_a_in, dial_b_in,
			panel_operation_in, setting_freq_in};
		pin_sync_reg <= pin_meta_reg;
		pin_prev_reg <= pin_sync_reg;
	end
	logic mode_k, set_k, stop_k, dial_a, dial_b, panel_op, freq_mode;
	assign {mode_k, set_k, stop_k, dial_a, dial_b, panel_op, freq_mode} = pin_sync_reg;
	logic set_rise, stop_rise, dial_click, dial_up, activity;
	assign set_rise = set_k & ~pin_prev_reg[5];
	assign stop_rise = stop_k & ~pin_prev_reg[4];
	// one click per full quadrature cycle on the a rising edge, 24 per turn
	assign dial_click = dial_a & ~pin_prev_reg[3];
	assign dial_up = ~dial_b;
	assign activity = dial_click | set_rise | (mode_k & ~pin_prev_reg[6]);
	// ************************************************************
	// configuration
	// ************************************************************
	pdk_cfg_s cfg_reg;
	logic [19:0] freq_reg;
	logic [19:0] freq_next;
	logic restore_err_reg;
	logic list_valid_reg;
	logic [3:0] list_reg;
	logic lock_armed;
	assign lock_armed = (cfg_reg.lock_sel == LOCK_ARM_FREQ) || (cfg_reg.lock_sel == LOCK_ARM_POT);
	// ************************************************************
	// lock state machine
	// ************************************************************
	pdk_lock_e lock_reg;
	logic [31:0] hold_cnt_reg;
	logic hold_done_reg;
	logic locked;
	assign locked = (lock_reg != PDK_UNLOCKED);
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			hold_cnt_reg <= 32'h0;
			hold_done_reg <= 1'b0;
		end else if (!mode_k || (locked && (dial_click || set_rise))) begin
			hold_cnt_reg <= 32'h0;
			hold_done_reg <= 1'b0;
		end else if (hold_cnt_reg < 32'(HOLD_COUNT)) begin
			hold_cnt_reg <= hold_cnt_reg + 32'h1;
			hold_done_reg <= 1'b0;
		end else begin
			// one pulse per hold; parking one past the limit keeps a long hold from wrapping round
			hold_done_reg <= (hold_cnt_reg == 32'(HOLD_COUNT));
			if (hold_cnt_reg == 32'(HOLD_COUNT)) begin
				hold_cnt_reg <= hold_cnt_reg + 32'h1;
			end
		end
	end
	logic [31:0] idle_cnt_reg;
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in || activity) begin
			idle_cnt_reg <= 32'h0;
		end else if (idle_cnt_reg < 32'(HOLD_COUNT)) begin
			idle_cnt_reg <= idle_cnt_reg + 32'h1;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			lock_reg <= PDK_UNLOCKED;
		end else begin
			unique case (lock_reg)
				PDK_UNLOCKED: begin
					if (hold_done_reg && lock_armed) begin
						lock_reg <= PDK_LOCKED;
					end
				end
				PDK_LOCKED: begin
					if (hold_done_reg) begin
						lock_reg <= PDK_UNLOCKED;
					end else if (dial_click || set_rise) begin
						lock_reg <= PDK_NOTICE;
					end
				end
				PDK_NOTICE: begin
					if (hold_done_reg) begin
						lock_reg <= PDK_UNLOCKED;
					end else if (idle_cnt_reg >= 32'(HOLD_COUNT)) begin
						lock_reg <= PDK_LOCKED;
					end
				end
				default: lock_reg <= PDK_UNLOCKED;
			endcase
		end
	end
	// stop stays live whatever the lock says
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			stop_out <= 1'b0;
		end else begin
			stop_out <= stop_rise;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			lock_notice_out <= 1'b0;
			key_beep_out <= 1'b0;
			lcd_contrast_out <= CONTRAST_RST;
		end else begin
			lock_notice_out <= (lock_reg == PDK_NOTICE);
			key_beep_out <= cfg_reg.beep_en & (set_rise | stop_rise);
			lcd_contrast_out <= cfg_reg.contrast;
		end
	end
	// ************************************************************
	// dial step and frequency
	// ************************************************************
	function automatic logic [19:0] eff_step(input pdk_cfg_s c, input logic [19:0] f);
		logic [19:0] s;
		s = pdk_step(c.step_sel);
		if (c.speed_disp && f >= SPEED_1000 && s < 20'h00064) begin
			s = 20'h00064;
		end else if (f >= FREQ_100 && s < 20'h0000A) begin
			s = 20'h0000A;
		end
		return s;
	endfunction : eff_step
	// machine speed values run past the frequency ceiling, so only the field width bounds them
	function automatic logic [19:0] freq_lim(input pdk_cfg_s c);
		return c.speed_disp ? 20'hFFFFF : FREQ_MAX;
	endfunction : freq_lim
	always_comb begin
		logic [19:0] s;
		s = eff_step(cfg_reg, freq_reg);
		freq_next = freq_reg;
		// step setting only while the dial edits the set frequency
		if (dial_click && !locked && freq_mode) begin
			if (dial_up) begin
				freq_next = (freq_lim(cfg_reg) - freq_reg < s) ? freq_lim(cfg_reg) : freq_reg + s;
			end else begin
				freq_next = (freq_reg < s) ? 20'h0 : freq_reg - s;
			end
		end
	end
	// ************************************************************
	// axi4-lite slave
	// ************************************************************
	logic aw_full_reg, w_full_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic do_write;
	assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
	assign s_axi_wready = ~w_full_reg & ~s_axi_bvalid;
	assign do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
			end
			if (do_write) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_reg > ADDR_LIST || aw_addr_reg[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	logic ext_open, wr_ctrl, wr_set, wr_freq, wr_cmd;
	assign ext_open = (cfg_reg.ext_disp == 14'h0);
	assign wr_ctrl = do_write && aw_addr_reg == ADDR_CTRL;
	assign wr_set = do_write && aw_addr_reg == ADDR_SETTINGS;
	assign wr_freq = do_write && aw_addr_reg == ADDR_FREQ;
	assign wr_cmd = do_write && aw_addr_reg == ADDR_CMD && w_data_reg[0];
	logic restore_ok;
	assign restore_ok = wr_cmd && !cfg_reg.write_protect && panel_op;
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			cfg_reg <= '{LOCK_SEL_RST, STEP_RST, BEEP_RST, CONTRAST_RST, EXT_RST, 1'b0, 1'b0};
			freq_reg <= FREQ_RST;
		end else begin
			freq_reg <= freq_next;
			if (restore_ok) begin
				// calibration and terminal settings live outside this block and are untouched
				cfg_reg.lock_sel <= LOCK_SEL_RST;
				cfg_reg.step_sel <= STEP_RST;
				cfg_reg.beep_en <= BEEP_RST;
				cfg_reg.contrast <= CONTRAST_RST;
				cfg_reg.ext_disp <= EXT_RST;
				cfg_reg.speed_disp <= 1'b0;
				freq_reg <= FREQ_RST;
			end
			if (wr_ctrl && (s_axi_wstrb[0] || s_axi_wstrb == 4'h0 || 1'b1)) begin
				cfg_reg.write_protect <= w_data_reg[0];
				cfg_reg.speed_disp <= w_data_reg[1];
				cfg_reg.ext_disp <= w_data_reg[29:16];
				if (w_data_reg[11:8] <= 4'h1 || w_data_reg[11:8] == LOCK_ARM_FREQ
					|| w_data_reg[11:8] == LOCK_ARM_POT) begin
					cfg_reg.lock_sel <= w_data_reg[11:8];
				end
			end
			// write protect does not gate beep and contrast
			if (wr_set && ext_open) begin
				if (w_data_reg[2:0] <= 3'h4) begin
					cfg_reg.step_sel <= w_data_reg[2:0];
				end
				cfg_reg.beep_en <= w_data_reg[8];
				cfg_reg.contrast <= w_data_reg[21:16];
			end
			if (wr_freq && !cfg_reg.write_protect && w_data_reg[19:0] <= freq_lim(cfg_reg)) begin
				freq_reg <= w_data_reg[19:0];
			end
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			restore_err_reg <= 1'b0;
		end else if (wr_cmd && !panel_op) begin
			restore_err_reg <= 1'b1;
		end else if (set_rise || restore_ok) begin
			restore_err_reg <= 1'b0;
		end
	end
	// the idle counter saturates, so the alternation needs a pace of its own
	logic [31:0] blink_cnt_reg;
	logic blink_reg;
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in || !restore_err_reg) begin
			blink_cnt_reg <= 32'h0;
			blink_reg <= 1'b1;
		end else if (blink_cnt_reg >= 32'(HOLD_COUNT / 4)) begin
			blink_cnt_reg <= 32'h0;
			blink_reg <= ~blink_reg;
		end else begin
			blink_cnt_reg <= blink_cnt_reg + 32'h1;
		end
	end
	assign restore_error_out = restore_err_reg & blink_reg;
	// changed list snapshot, rebuilt on write of bit1 to the command register
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			list_reg <= 4'h0;
			list_valid_reg <= 1'b0;
		end else if (do_write && aw_addr_reg == ADDR_CMD && w_data_reg[1]) begin
			list_valid_reg <= 1'b1;
			// bit3 extended select always listed; calibration never listed
			list_reg[3] <= 1'b1;
			list_reg[2] <= (cfg_reg.contrast != CONTRAST_RST); // contrast is simple-mode
			list_reg[1] <= (cfg_reg.beep_en != BEEP_RST) && cfg_reg.ext_disp != EXT_SIMPLE;
			list_reg[0] <= (cfg_reg.step_sel != STEP_RST) && cfg_reg.ext_disp != EXT_SIMPLE;
		end
	end
	// ************************************************************
	// read channel
	// ************************************************************
	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_CTRL: s_axi_rdata <= {2'h0, cfg_reg.ext_disp, 4'h0, cfg_reg.lock_sel, 6'h0,
					cfg_reg.speed_disp, cfg_reg.write_protect};
				ADDR_SETTINGS: s_axi_rdata <= {10'h0, cfg_reg.contrast, 7'h0, cfg_reg.beep_en, 5'h0,
					cfg_reg.step_sel};
				ADDR_FREQ: s_axi_rdata <= {12'h0, freq_reg};
				ADDR_STATUS: s_axi_rdata <= {27'h0, restore_err_reg, lock_reg == PDK_NOTICE, locked,
					lock_armed, panel_op};
				ADDR_CMD: s_axi_rdata <= 32'h0;
				ADDR_LIST: s_axi_rdata <= {27'h0, list_valid_reg, list_reg};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : pdk_panel

// file: pdk_operator.sv
// operator model: panel keys and quadrature setting dial
`timescale 1ns/1ps
module pdk_operator (
	// clock
	input wire logic sys_clk_in,
	// keys and dial contacts
	output logic mode_key_out,
	output logic set_key_out,
	output logic stop_key_out,
	output logic dial_a_out,
	output logic dial_b_out
);
	logic [2:0] key_reg = 3'h0;
	assign mode_key_out = key_reg[0];
	assign set_key_out = key_reg[1];
	assign stop_key_out = key_reg[2];
	initial begin
		dial_a_out = 1'b0;
		dial_b_out = 1'b1;
	end
	// four quiet cycles after release let the input synchronisers settle
	task automatic press(input int k, input int n);
		@(posedge sys_clk_in);
		key_reg[k] <= 1'b1;
		repeat (n) @(posedge sys_clk_in);
		key_reg[k] <= 1'b0;
		repeat (4) @(posedge sys_clk_in);
	endtask : press
	// b low at the rising edge of a means one step up
	task automatic turn(input logic up, input int n);
		repeat (n) begin
			@(posedge sys_clk_in);
			dial_b_out <= !up;
			@(posedge sys_clk_in);
			dial_a_out <= 1'b1;
			repeat (4) @(posedge sys_clk_in);
			dial_a_out <= 1'b0;
			dial_b_out <= up;
			repeat (4) @(posedge sys_clk_in);
		end
	endtask : turn
endmodule : pdk_operator

// file: pdk_panel_asserts.sv
// concurrent checks on the ports of the panel block
`timescale 1ns/1ps
module pdk_panel_asserts import pdk_pkg::*; #(
	parameter int HOLD_COUNT = HOLD_CYCLES
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	// panel
	input wire logic mode_key_in,
	input wire logic set_key_in,
	input wire logic stop_key_in,
	input wire logic dial_a_in,
	input wire logic lock_notice_out,
	input wire logic stop_out,
	input wire logic key_beep_out,
	input wire logic [5:0] lcd_contrast_out
);
	// ****************
	// idle time at the pins
	// ****************
	// rising edges only, as the design counts activity; the stop key is not activity, and this
	// count starts a few cycles ahead of the design's because it skips the synchronisers
	logic [2:0] pin_prev_reg;
	logic [31:0] idle_cnt_reg;
	always_ff @(posedge sys_clk_in) begin
		pin_prev_reg <= {mode_key_in, set_key_in, dial_a_in};
		if (!rst_n_in || (|({mode_key_in, set_key_in, dial_a_in} & ~pin_prev_reg))) begin
			idle_cnt_reg <= 32'h0;
		end else if (idle_cnt_reg != 32'hFFFFFFFF) begin
			idle_cnt_reg <= idle_cnt_reg + 32'h1;
		end
	end
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while a response waits");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while a response waits");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_LIST |=> s_axi_rresp == RESP_SLVERR)
		else $error("unmapped read not refused");
	a_stop_follows: assert property ($rose(stop_key_in) |-> ##[1:5] stop_out)
		else $error("stop key lost");
	a_stop_pulse: assert property (stop_out |=> !stop_out)
		else $error("stop pulse too long");
	a_beep_pulse: assert property (key_beep_out |=> !key_beep_out)
		else $error("beep pulse too long");
	a_reset_values: assert property (disable iff (1'b0) !rst_n_in |=> lcd_contrast_out == CONTRAST_RST && !stop_out)
		else $error("wrong value after reset");
	a_notice_min_idle: assert property ($fell(lock_notice_out) |-> idle_cnt_reg >= HOLD_COUNT)
		else $error("notice cleared too soon");
	a_notice_max_idle: assert property (idle_cnt_reg == HOLD_COUNT + 8 |-> !lock_notice_out)
		else $error("notice stays after idle time");
	c_notice: cover property ($rose(lock_notice_out));
	c_stop: cover property (stop_out);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : pdk_panel_asserts
bind pdk_panel pdk_panel_asserts #(.HOLD_COUNT(HOLD_COUNT)) i_chk (.sys_clk_in, .rst_n_in, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .mode_key_in, .set_key_in, .stop_key_in, .dial_a_in,
	.lock_notice_out, .stop_out, .key_beep_out, .lcd_contrast_out);

// file: pdk_panel_tb.sv
// self-checking testbench for the panel dial and key lock block
`timescale 1ns/1ps
module pdk_panel_tb import pdk_pkg::*;;
	localparam int HOLD = 50;
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic panel_operation_in = 1'b1, setting_freq_in = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic mode_key_in, set_key_in, stop_key_in, dial_a_in, dial_b_in;
	logic lock_notice_out, restore_error_out, stop_out, key_beep_out, blink_a;
	logic [5:0] lcd_contrast_out;
	logic [31:0] fail_count = 32'h0, checked = 32'h0, beep_cnt = 32'h0, stop_cnt = 32'h0, freq = 32'h0;
	logic [31:0] step_tab [5] = '{32'h1, 32'h1, 32'hA, 32'h64, 32'h3E8};
	pdk_panel #(.HOLD_COUNT(HOLD)) i_dut (.sys_clk_in, .rst_n_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.mode_key_in, .set_key_in, .stop_key_in, .dial_a_in, .dial_b_in, .panel_operation_in, .setting_freq_in,
		.lock_notice_out, .restore_error_out, .stop_out, .key_beep_out, .lcd_contrast_out);
	pdk_operator i_op (.sys_clk_in, .mode_key_out(mode_key_in), .set_key_out(set_key_in),
		.stop_key_out(stop_key_in), .dial_a_out(dial_a_in), .dial_b_out(dial_b_in));
	initial begin
		forever #4 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) if (key_beep_out === 1'b1) beep_cnt <= beep_cnt + 32'h1;
	always @(posedge sys_clk_in) if (stop_out === 1'b1) stop_cnt <= stop_cnt + 32'h1;
	// ****************
	// tasks
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		@(posedge sys_clk_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk_in);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
		@(posedge sys_clk_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk_in);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk({30'h0, s_axi_rresp}, {30'h0, er});
		if (er == RESP_OKAY) chk(s_axi_rdata, e);
	endtask : rd
	task automatic click(input logic up, input int n, input logic [31:0] e);
		i_op.turn(up, n);
		rd(ADDR_FREQ, e);
	endtask : click
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done
	task automatic give_verdict;
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict
	// ****************
	// sequence
	// ****************
	// the whole run needs under a thousand cycles, so this only cuts a hang
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		fail_count++;
		give_verdict();
	end
	initial begin
		repeat (4) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		chk({26'h0, lcd_contrast_out}, 32'h3A);
		rd(ADDR_SETTINGS, 32'h003A0100);
		rd(ADDR_CTRL, 32'h270F0000);
		wr(ADDR_SETTINGS, 32'h003F0003);
		rd(ADDR_SETTINGS, 32'h003A0100);
		i_op.press(1, 2);
		chk(beep_cnt, 32'h1);
		done("reset");
		wr(ADDR_CTRL, 32'h0);
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_SETTINGS, 32'h003F0000 | 32'(i));
			freq += step_tab[i];
			click(1'b1, 1, freq);
		end
		chk({26'h0, lcd_contrast_out}, 32'h3F);
		wr(ADDR_SETTINGS, 32'h003F0003);
		freq -= 32'h64;
		click(1'b0, 1, freq);
		wr(ADDR_SETTINGS, 32'h003F0002);
		freq += 32'hF0;
		click(1'b1, 24, freq);
		setting_freq_in <= 1'b0;
		click(1'b1, 1, freq);
		setting_freq_in <= 1'b1;
		wr(ADDR_FREQ, 32'h2710);
		wr(ADDR_SETTINGS, 32'h003F0001);
		freq = 32'h271A;
		click(1'b1, 1, freq);
		done("dial");
		wr(ADDR_CTRL, 32'h00000100);
		i_op.press(0, HOLD + 10);
		rd(ADDR_STATUS, 32'h1);
		wr(ADDR_CTRL, 32'h00000A00);
		i_op.press(0, HOLD + 10);
		rd(ADDR_STATUS, 32'h7);
		click(1'b1, 1, freq);
		chk({31'h0, lock_notice_out}, 32'h1);
		i_op.press(2, 2);
		chk(stop_cnt, 32'h1);
		repeat (HOLD + 10) @(posedge sys_clk_in);
		chk({31'h0, lock_notice_out}, 32'h0);
		i_op.press(0, HOLD + 10);
		freq += 32'hA;
		click(1'b1, 1, freq);
		done("lock");
		panel_operation_in <= 1'b0;
		wr(ADDR_CMD, 32'h1);
		rd(ADDR_STATUS, 32'h12);
		blink_a = restore_error_out;
		repeat (HOLD / 4 + 1) @(posedge sys_clk_in);
		chk({31'h0, blink_a ^ restore_error_out}, 32'h1);
		rd(ADDR_SETTINGS, 32'h003F0001);
		panel_operation_in <= 1'b1;
		i_op.press(1, 2);
		rd(ADDR_STATUS, 32'h3);
		chk({31'h0, restore_error_out}, 32'h0);
		chk(beep_cnt, 32'h1);
		wr(ADDR_CTRL, 32'h00000A01);
		wr(ADDR_CMD, 32'h1);
		rd(ADDR_SETTINGS, 32'h003F0001);
		wr(ADDR_CTRL, 32'h00000A00);
		wr(ADDR_CMD, 32'h1);
		rd(ADDR_SETTINGS, 32'h003A0100);
		rd(ADDR_CTRL, 32'h270F0000);
		rd(ADDR_FREQ, 32'h0);
		done("restore");
		wr(ADDR_CMD, 32'h2);
		rd(ADDR_LIST, 32'h18);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_SETTINGS, 32'h003B0100);
		rd(ADDR_LIST, 32'h18);
		wr(ADDR_CMD, 32'h2);
		rd(ADDR_LIST, 32'h1C);
		wr(ADDR_CTRL, 32'h2);
		wr(ADDR_FREQ, 32'h186A0);
		click(1'b1, 1, 32'h18704);
		rd(8'h40, 32'h0, RESP_SLVERR);
		wr(8'h40, 32'h0, RESP_SLVERR);
		done("list");
		give_verdict();
	end
endmodule : pdk_panel_tb
